//--- design/csc_pkg.sv
`default_nettype none
package csc_pkg;
    // ************************************************************
    // Register map (byte addresses, one 32-bit word each)
    // ************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] INFO_OFS = 8'h08;

    // ************************************************************
    // Control word layout
    // ************************************************************
    localparam int CTRL_W = 7;
    typedef struct packed {
        logic out_signed;
        logic in_signed;
        logic saturate;
        logic [2:0] round_mode;
        logic preset;
    } csc_ctrl_s;

    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h10;

    typedef enum logic [2:0] {
        RND_NONE,
        RND_UP,
        RND_AWAY,
        RND_TOWARD,
        RND_EVEN
    } csc_round_e;

    localparam logic PRESET_RGB2YCC = 1'b0;
    localparam logic PRESET_YCC2RGB = 1'b1;

    // ************************************************************
    // Fixed-point coefficients, scaled by 2**COEF_FRAC
    // ************************************************************
    localparam int COEF_W = 16;
    localparam int COEF_FRAC = 10;
    localparam int COEF [0:1][0:2][0:2] = '{
        '{'{263, 516, 100}, '{-152, -298, 450}, '{450, -377, -73}},
        '{'{1192, 0, 1634}, '{1192, -401, -833}, '{1192, 2065, 0}}
    };
    localparam int OFFSET [0:1][0:2] = '{
        '{16384, 131072, 131072},
        '{-228262, 138871, -283443}
    };

    // ************************************************************
    // Pipeline depth in clock cycles
    // ************************************************************
    localparam int LAT_PAR = 4;
    localparam int SEQ_GATHER = 2;
    localparam int LAT_SEQ = LAT_PAR + SEQ_GATHER;
endpackage
`default_nettype wire

//--- design/csc_top.sv
// The implementer's own choices: the APB slave port and the register addresses.
`default_nettype none
// How it works
// - Parameter SEQUENTIAL picks three-lane parallel or single-lane sequential datapath.
// - Output planes are exactly OUT_W bits wide.
// - Latency is fixed: four cycles parallel, six from first sample sequential.
// - Mode none truncates dropped fraction bits with no correction.
// - Round-up mode: exact half goes up; negative halves go away from zero.
// - Away mode: exact half moves away from zero.
// - Toward mode: exact half moves toward zero.
// - Convergent mode: exact half resolves to nearest even integer.
// - Saturation clamps to the largest or smallest output value by sign.
// - Parallel outputs all three planes together with output valid.
// - Sequential output gives planes on port zero over three consecutive cycles.
// - Preset zero computes RGB to YCbCr with its fixed matrix and offsets.
// - Preset one computes YCbCr to computer RGB with its matrix and offsets.
// - Clock enable used only when HAS_CE is set, else ignored.
// - Synchronous clear used only when HAS_SCLR is set, else ignored.
// - Input samples read as signed or unsigned per control bit.
// - Valid handshake honoured only when HAS_VALID is set.
module csc_top #(
    parameter int IN_W = 8,
    parameter int OUT_W = 8,
    parameter int TAG_W = 4,
    parameter bit SEQUENTIAL = 1'b0,
    parameter bit HAS_CE = 1'b1,
    parameter bit HAS_SCLR = 1'b1,
    parameter bit HAS_VALID = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ce_in,
    input wire logic sync_clear,
    input wire logic inp_valid,
    input wire logic [IN_W-1:0] plane0_in,
    input wire logic [IN_W-1:0] plane1_in,
    input wire logic [IN_W-1:0] plane2_in,
    input wire logic [TAG_W-1:0] tag_in,
    output logic out_valid,
    output logic [OUT_W-1:0] plane0_out,
    output logic [OUT_W-1:0] plane1_out,
    output logic [OUT_W-1:0] plane2_out,
    output logic [TAG_W-1:0] tag_out
);
    localparam int CW = csc_pkg::COEF_W;
    localparam int F = csc_pkg::COEF_FRAC;
    localparam int XW = IN_W + 1;
    localparam int PW = XW + CW;
    localparam int AW = PW + 3;
    localparam int IW = AW - F;
    localparam int LANES = SEQUENTIAL ? 1 : 3;
    localparam logic [F-1:0] HALF = F'(1 << (F - 1));
    localparam logic signed [IW-1:0] S_HI = IW'((64'sd1 <<< (OUT_W - 1)) - 64'sd1);
    localparam logic signed [IW-1:0] S_LO = IW'(-(64'sd1 <<< (OUT_W - 1)));
    localparam logic signed [IW-1:0] U_HI = IW'((64'sd1 <<< OUT_W) - 64'sd1);

    typedef enum {
        SQ_FIRST,
        SQ_SECOND,
        SQ_THIRD
    } csc_gather_e;

    // ************************************************************
    // Option gating
    // ************************************************************
    logic ce;
    logic sclr;
    logic vin;
    assign ce = !HAS_CE || ce_in;
    assign sclr = HAS_SCLR && sync_clear;
    assign vin = !HAS_VALID || inp_valid;

    // ************************************************************
    // APB slave: zero wait states
    // ************************************************************
    csc_pkg::csc_ctrl_s ctrl_q;
    logic [31:0] out_cnt_q;
    logic [31:0] prdata_q;
    logic addr_ok;
    logic setup;
    logic access;

    assign addr_ok = paddr == csc_pkg::CTRL_OFS || paddr == csc_pkg::STAT_OFS || paddr == csc_pkg::INFO_OFS;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && !addr_ok;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= csc_pkg::CTRL_RST;
        end else if (access && pwrite && paddr == csc_pkg::CTRL_OFS) begin
            ctrl_q <= pwdata[csc_pkg::CTRL_W-1:0];
        end
    end

    // Read data is fetched in the setup cycle so it is stable in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            unique case (paddr)
                csc_pkg::CTRL_OFS: prdata_q <= 32'(ctrl_q);
                csc_pkg::STAT_OFS: prdata_q <= out_cnt_q;
                csc_pkg::INFO_OFS: prdata_q <= {15'h0000, SEQUENTIAL, 8'(OUT_W),
                                                8'(SEQUENTIAL ? csc_pkg::LAT_SEQ : csc_pkg::LAT_PAR)};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic signed [XW-1:0] ext_in(input logic [IN_W-1:0] d, input logic sgn);
        ext_in = {sgn & d[IN_W-1], d};
    endfunction

    function automatic logic signed [CW-1:0] coef_of(input logic p, input logic [1:0] r, input int c);
        coef_of = CW'(csc_pkg::COEF[p][r][c]);
    endfunction

    function automatic logic signed [AW-1:0] ofs_of(input logic p, input logic [1:0] r);
        ofs_of = AW'(csc_pkg::OFFSET[p][r]);
    endfunction

    function automatic logic signed [IW-1:0] round_it(input logic signed [AW-1:0] v, input logic [2:0] mode);
        logic signed [IW-1:0] fl;
        logic [F-1:0] fr;
        logic neg;
        logic bump;
        fl = v[AW-1:F];
        fr = v[F-1:0];
        neg = v[AW-1];
        bump = 1'b0;
        unique case (mode)
            csc_pkg::RND_NONE: bump = 1'b0;
            csc_pkg::RND_UP: bump = fr > HALF || (fr == HALF && !neg);
            csc_pkg::RND_AWAY: bump = fr > HALF || (fr == HALF && !neg);
            csc_pkg::RND_TOWARD: bump = fr > HALF || (fr == HALF && neg);
            csc_pkg::RND_EVEN: bump = fr > HALF || (fr == HALF && fl[0]);
            default: bump = 1'b0;
        endcase
        round_it = fl + IW'(bump);
    endfunction

    function automatic logic [OUT_W-1:0] fit(input logic signed [IW-1:0] r, input logic sat, input logic osg);
        logic signed [IW-1:0] hi;
        logic signed [IW-1:0] lo;
        hi = osg ? S_HI : U_HI;
        lo = osg ? S_LO : '0;
        if (sat && r > hi) begin
            fit = hi[OUT_W-1:0];
        end else if (sat && r < lo) begin
            fit = lo[OUT_W-1:0];
        end else begin
            fit = r[OUT_W-1:0];
        end
    endfunction

    // ************************************************************
    // Stage A: operand capture
    // ************************************************************
    logic signed [XW-1:0] x_q [3];
    logic [LANES-1:0] a_vld_q;
    logic [1:0] a_row_q [LANES];
    logic [TAG_W-1:0] a_tag_q;

    if (SEQUENTIAL) begin : g_seq
        csc_gather_e gat_q;
        logic signed [XW-1:0] hold_q [2];
        logic [TAG_W-1:0] hold_tag_q;
        logic [1:0] iss_q;

        // Next pixel may gather while the previous one still issues rows
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                gat_q <= SQ_FIRST;
                hold_q[0] <= '0;
                hold_q[1] <= '0;
                hold_tag_q <= '0;
                x_q[0] <= '0;
                x_q[1] <= '0;
                x_q[2] <= '0;
                a_tag_q <= '0;
            end else if (sclr) begin
                gat_q <= SQ_FIRST;
            end else if (ce) begin
                unique case (gat_q)
                    SQ_FIRST: begin
                        if (vin) begin
                            hold_q[0] <= ext_in(plane0_in, ctrl_q.in_signed);
                            hold_tag_q <= tag_in;
                            gat_q <= SQ_SECOND;
                        end
                    end
                    SQ_SECOND: begin
                        hold_q[1] <= ext_in(plane0_in, ctrl_q.in_signed);
                        gat_q <= SQ_THIRD;
                    end
                    SQ_THIRD: begin
                        x_q[0] <= hold_q[0];
                        x_q[1] <= hold_q[1];
                        x_q[2] <= ext_in(plane0_in, ctrl_q.in_signed);
                        a_tag_q <= hold_tag_q;
                        gat_q <= SQ_FIRST;
                    end
                endcase
            end
        end

        // One matrix row per cycle through a single lane
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                iss_q <= 2'h0;
                a_vld_q <= '0;
                a_row_q[0] <= 2'h0;
            end else if (sclr) begin
                iss_q <= 2'h0;
                a_vld_q <= '0;
            end else if (ce) begin
                if (gat_q == SQ_THIRD) begin
                    a_vld_q[0] <= 1'b1;
                    a_row_q[0] <= 2'h0;
                    iss_q <= 2'h1;
                end else begin
                    a_vld_q[0] <= iss_q != 2'h0;
                    a_row_q[0] <= iss_q;
                    iss_q <= iss_q == 2'h2 ? 2'h0 : (iss_q == 2'h0 ? 2'h0 : iss_q + 2'h1);
                end
            end
        end
    end else begin : g_par
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                a_vld_q <= '0;
                x_q[0] <= '0;
                x_q[1] <= '0;
                x_q[2] <= '0;
                a_tag_q <= '0;
                for (int l = 0; l < 3; l++) begin
                    a_row_q[l] <= 2'(l);
                end
            end else if (sclr) begin
                a_vld_q <= '0;
            end else if (ce) begin
                a_vld_q <= {3{vin}};
                x_q[0] <= ext_in(plane0_in, ctrl_q.in_signed);
                x_q[1] <= ext_in(plane1_in, ctrl_q.in_signed);
                x_q[2] <= ext_in(plane2_in, ctrl_q.in_signed);
                a_tag_q <= tag_in;
                for (int l = 0; l < 3; l++) begin
                    a_row_q[l] <= 2'(l);
                end
            end
        end
    end

    // ************************************************************
    // Stages B to D: multiply, sum and round, fit to width
    // ************************************************************
    logic signed [PW-1:0] prod_q [LANES][3];
    logic [1:0] b_row_q [LANES];
    logic signed [IW-1:0] rnd_q [LANES];
    logic [OUT_W-1:0] out_q [3];
    logic [2:0] vld_q;
    logic [TAG_W-1:0] tag_q [3];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int l = 0; l < LANES; l++) begin
                b_row_q[l] <= 2'h0;
                rnd_q[l] <= '0;
                for (int c = 0; c < 3; c++) begin
                    prod_q[l][c] <= '0;
                end
            end
        end else if (ce) begin
            for (int l = 0; l < LANES; l++) begin
                b_row_q[l] <= a_row_q[l];
                for (int c = 0; c < 3; c++) begin
                    prod_q[l][c] <= PW'(x_q[c]) * PW'(coef_of(ctrl_q.preset, a_row_q[l], c));
                end
                rnd_q[l] <= round_it(AW'(prod_q[l][0]) + AW'(prod_q[l][1]) + AW'(prod_q[l][2])
                                     + ofs_of(ctrl_q.preset, b_row_q[l]), ctrl_q.round_mode);
            end
        end
    end

    // Unused lanes of the sequential form keep their reset zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int l = 0; l < 3; l++) begin
                out_q[l] <= '0;
            end
        end else if (ce) begin
            for (int l = 0; l < LANES; l++) begin
                out_q[l] <= fit(rnd_q[l], ctrl_q.saturate, ctrl_q.out_signed);
            end
        end
    end

    // Valid and tag ride alongside the data stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vld_q <= 3'h0;
            for (int s = 0; s < 3; s++) begin
                tag_q[s] <= '0;
            end
        end else if (sclr) begin
            vld_q <= 3'h0;
        end else if (ce) begin
            vld_q <= {vld_q[1:0], a_vld_q[0]};
            tag_q[0] <= a_tag_q;
            tag_q[1] <= tag_q[0];
            tag_q[2] <= tag_q[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_cnt_q <= 32'h0000_0000;
        end else if (ce && vld_q[2] && !sclr) begin
            out_cnt_q <= out_cnt_q + 32'h0000_0001;
        end
    end

    assign out_valid = vld_q[2];
    assign plane0_out = out_q[0];
    assign plane1_out = SEQUENTIAL ? '0 : out_q[1];
    assign plane2_out = SEQUENTIAL ? '0 : out_q[2];
    assign tag_out = tag_q[2];
endmodule // csc_top
`default_nettype wire

//--- tb/csc_src.sv
`default_nettype none
module csc_src #(
    parameter int IN_W = 8,
    parameter int TAG_W = 4
) (
    input wire logic pclk,
    input wire logic ce_in,
    input wire logic sync_clear,
    output logic inp_valid,
    output logic [IN_W-1:0] plane0_in,
    output logic [IN_W-1:0] plane1_in,
    output logic [IN_W-1:0] plane2_in,
    output logic [TAG_W-1:0] tag_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        inp_valid = 1'b0;
        plane0_in = '0;
        plane1_in = '0;
        plane2_in = '0;
        tag_in = '0;
    end
    // Whole pixel held until an enabled, uncleared edge takes it
    task automatic send(input logic [IN_W-1:0] a, b, c, input logic [TAG_W-1:0] t);
        inp_valid <= 1'b1;
        plane0_in <= a;
        plane1_in <= b;
        plane2_in <= c;
        tag_in <= t;
        do @(posedge pclk); while (!(ce_in === 1'b1 && sync_clear === 1'b0));
    endtask
    // Inverted lines so a stale sample can never pass for data
    task automatic release_bus();
        inp_valid <= 1'b0;
        plane0_in <= ~plane0_in;
        plane1_in <= ~plane1_in;
        plane2_in <= ~plane2_in;
        tag_in <= ~tag_in;
    endtask
endmodule // csc_src
`default_nettype wire

//--- tb/csc_top_checker.sv
`default_nettype none
module csc_top_checker #(
    parameter int IN_W = 8,
    parameter int OUT_W = 8,
    parameter int TAG_W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ce_in,
    input wire logic sync_clear,
    input wire logic inp_valid,
    input wire logic [IN_W-1:0] plane0_in,
    input wire logic [IN_W-1:0] plane1_in,
    input wire logic [IN_W-1:0] plane2_in,
    input wire logic [TAG_W-1:0] tag_in,
    input wire logic out_valid,
    input wire logic [OUT_W-1:0] plane0_out,
    input wire logic [OUT_W-1:0] plane1_out,
    input wire logic [OUT_W-1:0] plane2_out,
    input wire logic [TAG_W-1:0] tag_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic taken;
    logic mapped;
    assign taken = ce_in && inp_valid && !sync_clear;
    assign mapped = paddr inside {csc_pkg::CTRL_OFS, csc_pkg::STAT_OFS, csc_pkg::INFO_OFS};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ************************************************************
    // Pixel path timing
    // ************************************************************
    sequence s_taken;
        taken;
    endsequence
    sequence s_run3;
        (ce_in && !sync_clear) [*3];
    endsequence
    sequence s_out4;
        (ce_in && !sync_clear) [*4] ##1 out_valid;
    endsequence
    a_fixed_latency: assert property (s_taken ##1 s_run3 |=> out_valid)
        else $error("output valid missing four enabled edges after input");
    a_valid_cause: assert property (s_out4 |-> $past(taken, 4))
        else $error("output valid without input four enabled edges earlier");
    a_tag_align: assert property (s_out4 |-> tag_out == $past(tag_in, 4))
        else $error("tag out of step with its pixel");
    a_ce_freeze: assert property (!ce_in && !sync_clear |=>
        $stable({out_valid, tag_out, plane0_out, plane1_out, plane2_out}))
        else $error("outputs moved while clock enable low");
    a_clear_drop: assert property (sync_clear |=> !out_valid [*4])
        else $error("output valid survived a synchronous clear");
    // ************************************************************
    // Register port
    // ************************************************************
    a_ready_high: assert property (psel |-> pready)
        else $error("register port inserted a wait state");
    a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
        else $error("error on mapped access");
    a_unmapped_rd: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read returned nonzero");
endmodule // csc_top_checker
bind csc_top csc_top_checker #(.IN_W(IN_W), .OUT_W(OUT_W), .TAG_W(TAG_W)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_in(ce_in),
    .sync_clear(sync_clear), .inp_valid(inp_valid), .plane0_in(plane0_in), .plane1_in(plane1_in),
    .plane2_in(plane2_in), .tag_in(tag_in), .out_valid(out_valid), .plane0_out(plane0_out),
    .plane1_out(plane1_out), .plane2_out(plane2_out), .tag_out(tag_out));
`default_nettype wire

//--- tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, ce_in, sync_clear, inp_valid, out_valid, pready, pslverr;
    logic [7:0] paddr, plane0_in, plane1_in, plane2_in, plane0_out, plane1_out, plane2_out;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] tag_in, tag_out;
    logic pre, sat, isg, osg, err, ce_rand;
    logic [2:0] rnd;
    logic [27:0] exp_q[$];
    logic [27:0] exp_e;
    int n_mismatch = 0;
    int cmp_count = 0;
    int beats = 0;
    csc_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_in(ce_in),
        .sync_clear(sync_clear), .inp_valid(inp_valid), .plane0_in(plane0_in), .plane1_in(plane1_in),
        .plane2_in(plane2_in), .tag_in(tag_in), .out_valid(out_valid), .plane0_out(plane0_out),
        .plane1_out(plane1_out), .plane2_out(plane2_out), .tag_out(tag_out));
    csc_src src_u (
        .pclk(pclk), .ce_in(ce_in), .sync_clear(sync_clear), .inp_valid(inp_valid), .plane0_in(plane0_in),
        .plane1_in(plane1_in), .plane2_in(plane2_in), .tag_in(tag_in));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) ce_in <= ce_rand ? ($urandom_range(3) != 0) : 1'b1;
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // ************************************************************
    // Reference arithmetic, 10 fraction bits
    // ************************************************************
    function automatic longint raw(input int row, input logic [7:0] a, b, c);
        longint v0, v1, v2;
        v0 = a;
        v1 = b;
        v2 = c;
        if (isg) begin
            v0 = $signed(a);
            v1 = $signed(b);
            v2 = $signed(c);
        end
        return csc_pkg::COEF[pre][row][0] * v0 + csc_pkg::COEF[pre][row][1] * v1
            + csc_pkg::COEF[pre][row][2] * v2 + csc_pkg::OFFSET[pre][row];
    endfunction
    function automatic logic [7:0] conv(input int row, input logic [7:0] a, b, c);
        longint s, q, f, lo, hi;
        s = raw(row, a, b, c);
        q = s >>> 10;
        f = s & 1023;
        case (rnd)
            3'h1, 3'h2: if (f > 512 || (f == 512 && s >= 0)) q++;
            3'h3: if (f > 512 || (f == 512 && s < 0)) q++;
            3'h4: if (f > 512 || (f == 512 && q[0])) q++;
            default: ;
        endcase
        lo = osg ? -128 : 0;
        hi = osg ? 127 : 255;
        if (sat) q = (q < lo) ? lo : ((q > hi) ? hi : q);
        return q[7:0];
    endfunction
    // ************************************************************
    // Downstream sink and scoreboard
    // ************************************************************
    always @(posedge pclk) begin
        if (presetn === 1'b1) begin
            if (out_valid === 1'b1 && ce_in === 1'b1) begin
                if (exp_q.size() == 0) begin
                    check(32'h1, 32'h0);
                end else begin
                    exp_e = exp_q.pop_front();
                    if (sync_clear !== 1'b1) beats++;
                    check({tag_out, plane2_out, plane1_out, plane0_out}, exp_e);
                end
            end
            if (sync_clear === 1'b1) exp_q.delete();
            else if (inp_valid === 1'b1 && ce_in === 1'b1)
                exp_q.push_back({tag_in, conv(2, plane0_in, plane1_in, plane2_in),
                    conv(1, plane0_in, plane1_in, plane2_in), conv(0, plane0_in, plane1_in, plane2_in)});
        end
    end
    // Hunting an exact half fraction in row 0, up to 5000 tries, makes the tie cases likely
    task automatic send_px(input bit hunt);
        logic [7:0] a, b, c;
        a = 8'($urandom);
        b = 8'($urandom);
        c = 8'($urandom);
        for (int k = 0; hunt && k < 5000 && (raw(0, a, b, c) & 1023) != 512; k++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            c = 8'($urandom);
        end
        if ($urandom_range(3) == 0) begin
            src_u.release_bus();
            @(posedge pclk);
        end
        src_u.send(a, b, c, 4'($urandom));
    endtask
    task automatic drain();
        @(posedge pclk);
        for (int k = 0; k < 100 && exp_q.size() != 0; k++) @(posedge pclk);
        check(exp_q.size(), 32'h0);
        repeat (2) @(posedge pclk);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, sync_clear, ce_rand, pre, rnd, isg, osg} = '0;
        presetn = 1'b0;
        sat = 1'b1;
        void'($urandom(32'h48AAA6E3));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, csc_pkg::CTRL_OFS, 32'h0);
        check(rd, 32'h10);
        apb(1'b0, csc_pkg::INFO_OFS, 32'h0);
        check(rd, 32'h00000804);
        apb(1'b1, 8'h0C, 32'h7F);
        apb(1'b1, csc_pkg::STAT_OFS, 32'h55);
        apb(1'b0, 8'h0C, 32'h0);
        check(err, 32'h1);
        check(rd, 32'h0);
        for (int cfg = 0; cfg < 20; cfg++) begin
            pre = cfg[0];
            sat = cfg[1];
            rnd = 3'(cfg / 4);
            isg = 1'($urandom);
            osg = 1'($urandom);
            ce_rand = (cfg % 3 == 2);
            apb(1'b1, csc_pkg::CTRL_OFS, {25'h0, osg, isg, sat, rnd, pre});
            apb(1'b0, csc_pkg::CTRL_OFS, 32'h0);
            check(rd, {25'h0, osg, isg, sat, rnd, pre});
            for (int i = 0; i < 40; i++) begin
                send_px(i < 3);
                if (cfg == 4 && i == 20) begin
                    sync_clear <= 1'b1;
                    src_u.release_bus();
                    @(posedge pclk);
                    sync_clear <= 1'b0;
                end
            end
            src_u.release_bus();
            drain();
        end
        apb(1'b0, csc_pkg::STAT_OFS, 32'h0);
        check(rd, 32'(beats));
        end_of_test();
    end
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
